// ### test/tb_tsc_unit.sv
/* bench of tsc_unit; tsc_mem_model answers the table reads */
module tb_tsc_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import tsc_pkg::*;
`define CMP(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
  logic clk_sys_in = 1'h0, rst_in = 1'h1, start_in = 1'h0, exec_in = 1'h0;
  tsc_op_t op_in = TSC_OP_READ;
  logic [6:0] table_size_in = 7'h0a;
  logic [15:0] table_base_in = 16'h01f4, dest_addr_in = 16'h0005;
  logic [15:0] pointer_in = '0, src_a_in = '0, src_b_in = '0;
  logic [15:0] table_data_in, table_addr_out, wr_addr_out, wr_data_out;
  logic done_out, result_out, wr_en_out;
  int bad_count = 0, checked = 0;
  tsc_unit DUT (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .start_in(start_in),
    .exec_in(exec_in),
    .op_in(op_in),
    .table_base_in(table_base_in),
    .table_size_in(table_size_in),
    .pointer_in(pointer_in),
    .src_a_in(src_a_in),
    .src_b_in(src_b_in),
    .dest_addr_in(dest_addr_in),
    .table_data_in(table_data_in),
    .table_addr_out(table_addr_out),
    .done_out(done_out),
    .result_out(result_out),
    .wr_en_out(wr_en_out),
    .wr_addr_out(wr_addr_out),
    .wr_data_out(wr_data_out)
  );
  tsc_mem_model mem (.addr_in(table_addr_out), .data_out(table_data_in));
  initial forever #4 clk_sys_in = ~clk_sys_in;
  initial #20000 begin bad_count++; summarize(); end
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one request, answer judged one cycle later
  task automatic run(tsc_op_t o, logic x, logic [15:0] p, a, b, logic r, w);
    @(posedge clk_sys_in) #1;
    op_in = o;
    exec_in = x;
    pointer_in = p;
    src_a_in = a;
    src_b_in = b;
    start_in = 1'h1;
    @(posedge clk_sys_in) #1;
    start_in = 1'h0;
    `CMP("result", r, result_out)
    `CMP("write", w, wr_en_out)
    `CMP("done", 1'h1, done_out)
  endtask
  task automatic t_table();
    run(TSC_OP_READ, '1, 16'h0007, '0, '0, '0, '1);
    `CMP("rd_addr", 16'h0005, wr_addr_out)
    `CMP("rd_data", 16'h01fb ^ 16'ha5c3, wr_data_out)
    run(TSC_OP_WRITE, '1, 16'h0009, 16'h1234, '0, '0, '1);
    `CMP("wr_addr", 16'h01fd, wr_addr_out)
    `CMP("wr_data", 16'h1234, wr_data_out)
    run(TSC_OP_WRITE, '1, 16'h000a, 16'h5678, '0, '1, '0);
    run(TSC_OP_READ, '1, 16'h003f, '0, '0, '1, '0);
    run(TSC_OP_READ, '0, 16'h0001, '0, '0, '0, '0);
    `CMP("kept", 16'h1234, wr_data_out)
    `CMP("kept_addr", 16'h01fd, wr_addr_out)
  endtask
  task automatic t_cmp();
    run(TSC_OP_GT, '1, '0, 16'hff9c, 16'h09c4, '0, '0);
    run(TSC_OP_GE, '1, '0, 16'h0bb8, 16'h0bb8, '1, '0);
    run(TSC_OP_GE, '1, '0, 16'hfa24, 16'h0000, '0, '0);
    run(TSC_OP_EQ, '1, '0, 16'hfa24, 16'hfa24, '1, '0);
    run(TSC_OP_NE, '1, '0, 16'h000a, 16'h0000, '1, '0);
    run(TSC_OP_GT, '0, '0, 16'h0bb8, 16'h09c4, '0, '0);
    run(TSC_OP_GT, '1, '0, 16'h0bb8, 16'h09c4, '1, '0);
    run(TSC_OP_GT, '1, '0, 16'h0bb8, 16'h0bb8, '0, '0);
    run(TSC_OP_GT, '1, '0, 16'h7fff, 16'h8000, '1, '0);
    run(TSC_OP_GE, '1, '0, 16'h0000, 16'h8000, '1, '0);
    run(TSC_OP_EQ, '1, '0, 16'h0bb8, 16'h0000, '0, '0);
    run(TSC_OP_NE, '1, '0, 16'h0000, 16'h0000, '0, '0);
    run(TSC_OP_NE, '0, '0, 16'h000a, 16'h0000, '0, '0);
  endtask
  // size limits: a full table, then an empty and an oversized size
  task automatic t_size();
    table_size_in = 7'h40;
    run(TSC_OP_READ, '1, 16'h003f, '0, '0, '0, '1);
    `CMP("top_data", 16'h0233 ^ 16'ha5c3, wr_data_out)
    run(TSC_OP_READ, '1, 16'h0040, '0, '0, '1, '0);
    table_size_in = 7'h00;
    run(TSC_OP_WRITE, '1, 16'h0000, 16'h0042, '0, '1, '0);
    table_size_in = 7'h41;
    run(TSC_OP_WRITE, '1, 16'h0000, 16'h0042, '0, '1, '0);
    table_size_in = 7'h0a;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_in);
    #1 rst_in = 1'h0;
    t_table();
    t_size();
    t_cmp();
    summarize();
  end
endmodule

// ### test/tsc_mem_model.sv
/* register memory: combinational read of the table port */
module tsc_mem_model (
  input wire logic [15:0] addr_in,
  output logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign data_out = addr_in ^ 16'ha5c3; // each cell holds its own pattern
endmodule

// ### test/tsc_unit_checker.sv
/*
 * concurrent checks of the table select and compare unit's answers.
 * assumes it is bound into the unit and sees only its ports, all on the
 * one system clock with its synchronous reset.
 */
module tsc_unit_checker
  import tsc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic exec_in,
  input wire tsc_pkg::tsc_op_t op_in,
  input wire logic [tsc_pkg::SIZE_W-1:0] table_size_in,
  input wire logic [tsc_pkg::WORD_W-1:0] pointer_in,
  input wire logic [tsc_pkg::WORD_W-1:0] src_a_in,
  input wire logic [tsc_pkg::WORD_W-1:0] src_b_in,
  input wire logic [tsc_pkg::WORD_W-1:0] table_data_in,
  input wire logic done_out,
  input wire logic result_out,
  input wire logic wr_en_out,
  input wire logic [tsc_pkg::WORD_W-1:0] wr_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic go;
  logic ok;
  logic signed [WORD_W-1:0] a;
  logic signed [WORD_W-1:0] b;
  // taken request, pointer inside a legal table, signed operands
  assign go = start_in && exec_in;
  assign ok = pointer_in < table_size_in && table_size_in >= SIZE_MIN
    && table_size_in <= SIZE_MAX;
  assign a = src_a_in;
  assign b = src_b_in;
  // a taken table transfer request
  sequence table_req;
    go && op_in inside {TSC_OP_READ, TSC_OP_WRITE};
  endsequence
  done_pulse_a: assert property (
    start_in |=> done_out) else $error("done not raised after start");
  idle_quiet_a: assert property (
    !start_in |=> !done_out && !wr_en_out)
    else $error("answer without a start");
  off_result_a: assert property (
    start_in && !exec_in |=> !result_out && !wr_en_out)
    else $error("answer while input off");
  over_result_a: assert property (
    table_req ##0 !ok |=> result_out) else $error("pointer over not flagged");
  over_block_a: assert property (
    table_req ##0 !ok |=> !wr_en_out) else $error("pointer over wrote");
  read_data_a: assert property (
    go && op_in == TSC_OP_READ && ok |=> wr_en_out && !result_out
    && wr_data_out == $past(table_data_in)) else $error("table read data");
  write_data_a: assert property (
    go && op_in == TSC_OP_WRITE && ok |=> wr_en_out && !result_out
    && wr_data_out == $past(src_a_in)) else $error("table write data");
  gt_result_a: assert property (
    go && op_in == TSC_OP_GT |=> result_out == ($past(a) > $past(b)))
    else $error("greater-than result");
  ge_result_a: assert property (
    go && op_in == TSC_OP_GE |=> result_out == ($past(a) >= $past(b)))
    else $error("greater-or-equal result");
  eq_result_a: assert property (
    go && op_in == TSC_OP_EQ |=> result_out == ($past(a) == $past(b)))
    else $error("equal result");
  ne_result_a: assert property (
    go && op_in == TSC_OP_NE |=> result_out == ($past(a) != $past(b)))
    else $error("not-equal result");
endmodule
bind tsc_unit tsc_unit_checker chk (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .start_in(start_in),
  .exec_in(exec_in),
  .op_in(op_in),
  .table_size_in(table_size_in),
  .pointer_in(pointer_in),
  .src_a_in(src_a_in),
  .src_b_in(src_b_in),
  .table_data_in(table_data_in),
  .done_out(done_out),
  .result_out(result_out),
  .wr_en_out(wr_en_out),
  .wr_data_out(wr_data_out)
);

// ### verilog/tsc_cmp.sv
/*
 * signed word comparator, purely combinational.
 * assumes both operands are two's-complement words on the same clock.
 */
module tsc_cmp
  import tsc_pkg::*;
#(
  parameter int unsigned W = WORD_W
) (
  input wire logic [W-1:0] a_in,
  input wire logic [W-1:0] b_in,
  output logic gt_out,
  output logic eq_out
);
  // signed relation of the two operands
  always_comb begin
    gt_out = $signed(a_in) > $signed(b_in);
    eq_out = a_in == b_in;
  end
endmodule

// ### verilog/tsc_pkg.sv
/*
 * package for the table select and compare unit: opcodes, widths, limits.
 * assumes a single 125 mhz clock and an instruction sequencer that issues
 * one instruction per request pulse.
 */
package tsc_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned SIZE_W = 7;
  localparam int unsigned PTR_W = 6;
  localparam logic [SIZE_W-1:0] SIZE_MIN = 7'h01;
  localparam logic [SIZE_W-1:0] SIZE_MAX = 7'h40;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

  // instruction codes presented by the sequencer
  typedef enum logic [2:0] {
    TSC_OP_READ = 3'h0,
    TSC_OP_WRITE = 3'h1,
    TSC_OP_GT = 3'h2,
    TSC_OP_GE = 3'h3,
    TSC_OP_EQ = 3'h4,
    TSC_OP_NE = 3'h5
  } tsc_op_t;
endpackage

// ### verilog/tsc_unit.sv
/*
 * table select and compare unit: table read, table write, word compares.
 * a request is answered on the next clock edge: done, result and the
 * write strobe stand for one cycle, write address and data hold until
 * the next transfer. pointer and size compare as unsigned numbers, and a
 * size outside one to sixty-four blocks every table transfer.
 * assumes the sequencer presents one instruction with start_in held for one
 * cycle, and that it owns the register memory reached by the write port.
 * assumes the memory answers table_addr_out within the same cycle, which
 * is why that address is the one output not taken from a register.
 */
// Summary of operation
// - table read copies start plus pointer entry
// - table write stores source at start plus pointer
// - pointer at or past size blocks, output on
// - compare only while input on, else off
// - greater-than on when first exceeds second
// - greater-or-equal on when first at least second
// - equal on when operands identical
// - not-equal on when operands differ
// - operands are signed sixteen-bit integers
module tsc_unit
  import tsc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic exec_in,
  input wire tsc_pkg::tsc_op_t op_in,
  input wire logic [tsc_pkg::ADDR_W-1:0] table_base_in,
  input wire logic [tsc_pkg::SIZE_W-1:0] table_size_in,
  input wire logic [tsc_pkg::WORD_W-1:0] pointer_in,
  input wire logic [tsc_pkg::WORD_W-1:0] src_a_in,
  input wire logic [tsc_pkg::WORD_W-1:0] src_b_in,
  input wire logic [tsc_pkg::ADDR_W-1:0] dest_addr_in,
  input wire logic [tsc_pkg::WORD_W-1:0] table_data_in,
  output logic [tsc_pkg::ADDR_W-1:0] table_addr_out,
  output logic done_out,
  output logic result_out,
  output logic wr_en_out,
  output logic [tsc_pkg::ADDR_W-1:0] wr_addr_out,
  output logic [tsc_pkg::WORD_W-1:0] wr_data_out
);

  ////////////////////////////////////////////////////////////////////////////
  // comparator and pointer check

  logic gt;
  logic eq;
  logic taken;
  logic is_table;
  logic is_read;
  logic transfer;
  logic size_legal;
  logic ptr_inside;
  logic ptr_over;
  logic cmp_hit;
  logic [ADDR_W-1:0] entry_addr;

  tsc_cmp #(
    .W(WORD_W)
  ) u_cmp (
    .a_in(src_a_in),
    .b_in(src_b_in),
    .gt_out(gt),
    .eq_out(eq)
  );

  // entry address of table start plus pointer; the sum wraps, as the
  // caller keeps the whole table inside the register space
  function automatic logic [ADDR_W-1:0] entry(
    input logic [ADDR_W-1:0] base,
    input logic [WORD_W-1:0] ptr
  );
    entry = base + ADDR_W'(ptr);
  endfunction

  // true for the two table transfer codes
  function automatic logic table_op(
    input tsc_op_t op
  );
    table_op = (op == TSC_OP_READ) || (op == TSC_OP_WRITE);
  endfunction

  // relation picked by a compare code; other codes answer off
  function automatic logic relation(
    input tsc_op_t op,
    input logic greater,
    input logic equal
  );
    unique case (op)
      TSC_OP_GT: relation = greater;
      TSC_OP_GE: relation = greater || equal;
      TSC_OP_EQ: relation = equal;
      TSC_OP_NE: relation = !equal;
      default: relation = 1'b0;
    endcase
  endfunction

  // request decode: only a start with the input on sets result or writes; done answers any start
  always_comb begin
    taken = start_in && exec_in;
    is_table = table_op(op_in);
    is_read = op_in == TSC_OP_READ;
    transfer = taken && is_table && !ptr_over;
  end

  // table size must lie in its legal range
  always_comb begin
    size_legal = (table_size_in >= SIZE_MIN)
      && (table_size_in <= SIZE_MAX);
  end

  // pointer check: at or past the size, or a bad size, is over
  always_comb begin
    ptr_inside = pointer_in < WORD_W'(table_size_in);
    ptr_over = !(size_legal && ptr_inside);
  end

  // table port address, offered to the memory in the request cycle
  always_comb begin
    entry_addr = entry(table_base_in, pointer_in);
    table_addr_out = entry_addr;
  end

  // compare answer for the code on the port
  always_comb begin
    cmp_hit = relation(op_in, gt, eq);
  end

  ////////////////////////////////////////////////////////////////////////////
  // result and write port registers

  logic done_d, done_q;
  logic result_d, result_q;
  logic wr_en_d, wr_en_q;
  logic [ADDR_W-1:0] wr_addr_d, wr_addr_q;
  logic [WORD_W-1:0] wr_data_d, wr_data_q;

  // done: one answer per start, on or off, nothing carried over
  always_comb begin
    done_d = start_in;
  end

  // register done
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // result: off unless a taken request turns it on
  always_comb begin
    result_d = 1'b0;
    if (taken) begin
      if (is_table) begin
        result_d = ptr_over;
      end else begin
        result_d = cmp_hit;
      end
    end
  end

  // register result
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      result_q <= 1'b0;
    end else begin
      result_q <= result_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write port

  // write strobe: only a transfer inside the table writes
  always_comb begin
    wr_en_d = transfer;
  end

  // register the write strobe
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_en_q <= 1'b0;
    end else begin
      wr_en_q <= wr_en_d;
    end
  end

  // write address and data move only with a transfer, so a blocked or
  // idle request leaves the last written pair on the port
  always_comb begin
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    if (transfer && is_read) begin
      wr_addr_d = dest_addr_in;
      wr_data_d = table_data_in;
    end else if (transfer) begin
      wr_addr_d = entry_addr;
      wr_data_d = src_a_in;
    end
  end

  // register write address and data
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_addr_q <= ADDR_RST;
      wr_data_q <= WORD_RST;
    end else begin
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from its register

  assign done_out = done_q;
  assign result_out = result_q;
  assign wr_en_out = wr_en_q;
  assign wr_addr_out = wr_addr_q;
  assign wr_data_out = wr_data_q;
endmodule
